// ### pme_pkg.sv
/*
 * Constants and types shared by the program-mode entry controller and its
 * serial link receiver.
 * Assumes a 14-bit word, a 14-bit programming address space and 8K words
 * of program memory.
 */
package pme_pkg;

    localparam int          WORD_W      = 14;
    localparam int          ADDR_W      = 14;
    localparam int          PMEM_AW     = 13;
    localparam int          PMEM_DEPTH  = 8192;
    localparam int          ID_COUNT    = 4;
    localparam int          ID_IW       = 2;

    // programming address map
    localparam logic [13:0] ID_BASE     = 14'h2000;
    localparam logic [13:0] ID_LAST     = 14'h2003;
    localparam logic [13:0] CFG_ADDR    = 14'h2007;

    // erased state of configuration and id words
    localparam logic [13:0] CFG_ERASED  = 14'h3FFF;
    localparam logic [13:0] ID_ERASED   = 14'h3FFF;
    localparam logic [13:0] WORD_ZERO   = 14'h0000;

    // configuration word fields
    localparam int          CFG_LVP_BIT = 7;
    localparam int          CFG_CP0_BIT = 4;
    localparam int          CFG_CP1_BIT = 5;
    localparam logic [1:0]  CP_NONE     = 2'h3;

    // frame layout, counted in link clock edges from frame start
    localparam logic [4:0]  FR_OP_END   = 5'h01;
    localparam logic [4:0]  FR_ADDR_END = 5'h0F;
    localparam logic [4:0]  FR_LAST     = 5'h1D;
    localparam logic [4:0]  FR_ZERO     = 5'h00;
    localparam logic [4:0]  FR_STEP     = 5'h01;
    localparam int          RD_BEATS    = 14;

    typedef enum logic [1:0] {
        PME_IDLE = 2'b00,
        PME_HV   = 2'b01,
        PME_LV   = 2'b10
    } pme_mode_t;

    typedef enum logic [1:0] {
        OP_READ  = 2'b00,
        OP_WRITE = 2'b01,
        OP_BULK  = 2'b10,
        OP_RSVD  = 2'b11
    } pme_op_t;

endpackage

// ### pme_link.sv
/*
 * Link-side frame receiver of the program-mode entry controller, clocked
 * by the programmer's own clock.
 * Assumes the clock runs only inside a session; the data pin is sampled on
 * the rising link edge; requests leave by toggle handshake, read data
 * returns on a word that is stable while the answer toggle is in flight.
 */
`timescale 1ns/1ps
module pme_link
    import pme_pkg::*;
(
    input  wire logic              link_clk_i,     // programmer clock
    input  wire logic              arst_n_i,       // async reset, active low
    input  wire logic              session_i,      // session level, main domain
    input  wire logic              link_data_i,    // data pin level
    input  wire logic              ack_toggle_i,   // answer toggle, main domain
    input  wire logic [WORD_W-1:0] rsp_data_i,     // read answer word
    output logic                   link_data_o,    // data pin drive value
    output logic                   link_data_oe_o, // data pin drive enable
    output logic                   req_toggle_o,   // request toggle
    output logic [1:0]             req_op_o,       // request operation
    output logic [ADDR_W-1:0]      req_addr_o,     // request address
    output logic [WORD_W-1:0]      req_wdata_o     // request write word
);

    typedef struct packed {
        logic              sess_meta;
        logic              sess;
        logic              ack_meta;
        logic              ack_s;
        logic              ack_seen;
        logic              req_tog;
        logic [4:0]        cnt;
        logic [1:0]        op;
        logic [13:0]       shreg;
        logic [13:0]       addr;
        logic [1:0]        req_op;
        logic [13:0]       req_addr;
        logic [13:0]       req_wdata;
        logic [13:0]       rdata;
        logic [13:0]       outreg;
        logic              dout;
        logic              doe;
        logic [4:0]        run;
    } pme_lst_t;

    pme_lst_t s;
    pme_lst_t next_s;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s           = s;
        next_s.sess_meta = session_i;
        next_s.sess      = s.sess_meta;
        next_s.ack_meta  = ack_toggle_i;
        next_s.ack_s     = s.ack_meta;
        if (s.ack_s != s.ack_seen) begin
            next_s.ack_seen = s.ack_s;
            next_s.rdata    = rsp_data_i;
        end
        if (!s.sess) begin
            next_s.cnt = FR_ZERO;
            next_s.doe = 1'b0;
        end else begin
            // clock and data only: each frame is op, address, data, lsb first
            next_s.shreg = {link_data_i, s.shreg[13:1]};                      // R5
            next_s.cnt   = (s.cnt == FR_LAST) ? FR_ZERO : s.cnt + FR_STEP;   // R5
            if (s.cnt == FR_OP_END) begin
                next_s.op = next_s.shreg[13:12];
            end
            if (s.cnt == FR_ADDR_END) begin
                next_s.addr   = next_s.shreg;
                next_s.outreg = s.rdata;
                next_s.dout   = s.rdata[0];
                next_s.doe    = (s.op == OP_READ);                           // R1
            end else if (s.cnt > FR_ADDR_END && s.cnt < FR_LAST) begin
                next_s.outreg = s.outreg >> 1;
                next_s.dout   = s.outreg[1];
            end
            if (s.cnt == FR_LAST) begin
                next_s.doe = 1'b0;
                // a frame that arrives while the last is unanswered is dropped
                if (s.req_tog == s.ack_seen) begin
                    next_s.req_op    = s.op;
                    next_s.req_addr  = s.addr;
                    next_s.req_wdata = next_s.shreg;
                    next_s.req_tog   = ~s.req_tog;
                end
            end
        end
        // consecutive drive length, read only by the drive-length check
        next_s.run = next_s.doe ? s.run + FR_STEP : FR_ZERO;
    end

    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link_data_o    = s.dout;
    assign link_data_oe_o = s.doe;
    assign req_toggle_o   = s.req_tog;
    assign req_op_o       = s.req_op;
    assign req_addr_o     = s.req_addr;
    assign req_wdata_o    = s.req_wdata;

    ////////////////////////////////////////////////////////////////////////
    a_frame_wrap: assert property (@(posedge link_clk_i) disable iff (!arst_n_i || !s.sess)  // R5
        s.cnt == FR_LAST |=> s.cnt == FR_ZERO)
        else $error("frame counter did not wrap after last bit");

    // length comes from the run counter: a long repetition is costly to check
    a_read_drive: assert property (@(posedge link_clk_i) disable iff (!arst_n_i || !s.sess)  // R5
        (s.cnt == FR_ADDR_END && s.op == OP_READ) |=> s.doe ##13 (s.run == RD_BEATS)
        ##1 !s.doe)
        else $error("read data phase not driven for fourteen bits");

endmodule // pme_link

// ### pme_ctrl.sv
/*
 * Program-mode entry controller: session entry by high voltage or by the
 * entry pin, entry-pin sharing, config and id words, verify read-out.
 * Assumes the voltage detector and entry pin are asynchronous pins, the
 * core's gpio drive is on clock_i, and the programmer clocks the link.
 */
// Operation
// R1: with no code protection, program memory reads back over the link.
// R2: four id words live at 2000h to 2003h.
// R3: id words are reachable only inside a programming session.
// R4: programmer should use only the four low bits of each id word.
// R5: serial link uses one programmer clock and one data line.
// R6: only ordinary programming over the link; bulk erase is refused.
// R7: erased low-voltage enable bit reads 1 and allows low-voltage entry.
// R8: while low-voltage entry is enabled, the entry pin is not gpio.
// R9: with low-voltage entry enabled, a 1 on the entry pin enters.
// R10: programmer holds reset pin at supply level during low-voltage entry.
// R11: high-voltage entry always works, whatever the enable bit says.
// R12: enable bit 0 makes the entry pin ordinary gpio; high voltage only.
// R13: enable bit writes accepted only in high-voltage entered sessions.
// R14: entry path is latched for the whole session.
`timescale 1ns/1ps
module pme_ctrl
    import pme_pkg::*;
(
    input  wire logic clock_i,                // system clock, 250 MHz
    input  wire logic arst_n_i,               // async reset, active low
    input  wire logic link_clk_i,             // programmer clock
    input  wire logic master_clear_pin_hv_i,  // high_programming_voltage seen
    input  wire logic program_entry_pin_i,    // entry pin level
    output logic      program_entry_pin_o,    // entry pin drive value
    output logic      program_entry_pin_oe_o, // entry pin drive enable
    input  wire logic gpio_out_i,             // core drive for shared pin
    input  wire logic gpio_oe_i,              // core enable for shared pin
    output logic      gpio_in_o,              // shared pin level to core
    input  wire logic link_data_i,            // data pin level
    output logic      link_data_o,            // data pin drive value
    output logic      link_data_oe_o,         // data pin drive enable
    output logic      program_mode_o,         // session active, core held
    output logic      hv_session_o,           // session entered by high voltage
    output logic      low_voltage_program_enable_o, // enable bit image
    output logic      cmd_reject_o            // refused command, one pulse
);

    typedef struct packed {
        logic                           hv_meta;
        logic                           hv_s;
        logic                           pgm_meta;
        logic                           pgm_s;
        logic                           req_meta;
        logic                           req_s;
        logic                           req_prev;
        pme_mode_t                      mode;
        logic [WORD_W-1:0]              cfg;
        logic [ID_COUNT-1:0][WORD_W-1:0] ids;
        logic [WORD_W-1:0]              rdata;
        logic                           ack_tog;
        logic                           reject;
        logic                           pin_o;
        logic                           pin_oe;
        logic                           gpio_in;
    } pme_st_t;

    pme_st_t s;
    pme_st_t next_s;

    logic [WORD_W-1:0]  pmem [PMEM_DEPTH];
    logic               pmem_we;

    logic               link_req_tog;
    logic [1:0]         link_op;
    logic [ADDR_W-1:0]  link_addr;
    logic [WORD_W-1:0]  link_wdata;
    logic               link_oe;
    pme_op_t            op;
    logic               req_new;
    logic               low_voltage_program_enable;
    logic               prot;
    logic               is_pm;
    logic               is_id;
    logic               is_cfg;
    logic [PMEM_AW-1:0] pm_idx;
    logic [ID_IW-1:0]   id_idx;
    logic [WORD_W-1:0]  id_word;
    logic [WORD_W-1:0]  cfg_wr;

    ////////////////////////////////////////////////////////////////////////
    pme_link u_link (
        .link_clk_i     (link_clk_i),
        .arst_n_i       (arst_n_i),
        .session_i      (program_mode_o),
        .link_data_i    (link_data_i),
        .ack_toggle_i   (s.ack_tog),
        .rsp_data_i     (s.rdata),
        .link_data_o    (link_data_o),
        .link_data_oe_o (link_oe),
        .req_toggle_o   (link_req_tog),
        .req_op_o       (link_op),
        .req_addr_o     (link_addr),
        .req_wdata_o    (link_wdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // request fields are stable here: the link holds them until answered
    assign op      = pme_op_t'(link_op);
    assign req_new = (s.req_s != s.req_prev);
    assign low_voltage_program_enable     = s.cfg[CFG_LVP_BIT];
    assign prot    = ({s.cfg[CFG_CP1_BIT], s.cfg[CFG_CP0_BIT]} != CP_NONE);
    assign is_pm   = !link_addr[PMEM_AW];
    assign is_id   = (link_addr >= ID_BASE) && (link_addr <= ID_LAST);
    assign is_cfg  = (link_addr == CFG_ADDR);
    assign pm_idx  = link_addr[PMEM_AW-1:0];
    assign id_idx  = link_addr[ID_IW-1:0];
    assign id_word = s.ids[id_idx];
    // the enable bit keeps its value unless the write may touch it
    assign cfg_wr  = (s.mode == PME_HV) ? link_wdata                          // R13
                   : {link_wdata[WORD_W-1:CFG_LVP_BIT+1], low_voltage_program_enable,
                      link_wdata[CFG_LVP_BIT-1:0]};

    always_comb begin
        next_s          = s;
        next_s.hv_meta  = master_clear_pin_hv_i;
        next_s.hv_s     = s.hv_meta;
        next_s.pgm_meta = program_entry_pin_i;
        next_s.pgm_s    = s.pgm_meta;
        next_s.req_meta = link_req_tog;
        next_s.req_s    = s.req_meta;
        next_s.req_prev = s.req_s;
        next_s.reject   = 1'b0;
        pmem_we         = 1'b0;

        // entry path is the state itself and holds until its own signal drops
        unique case (s.mode)
            PME_IDLE: begin
                if (s.hv_s) begin
                    next_s.mode = PME_HV;                                     // R11
                end else if (low_voltage_program_enable && s.pgm_s) begin
                    next_s.mode = PME_LV;                                     // R9
                end
            end
            PME_HV: begin
                if (!s.hv_s) begin
                    next_s.mode = PME_IDLE;                                   // R14
                end
            end
            PME_LV: begin
                if (!s.pgm_s) begin
                    next_s.mode = PME_IDLE;                                   // R14
                end
            end
            default: begin
                next_s.mode = PME_IDLE;
            end
        endcase

        // every request is answered so the link never waits forever
        if (req_new) begin
            next_s.ack_tog = ~s.ack_tog;
            if (s.mode != PME_IDLE) begin                                     // R3
                unique case (op)
                    OP_READ: begin
                        if (is_pm) begin
                            next_s.rdata = prot ? WORD_ZERO : pmem[pm_idx];  // R1
                        end else if (is_id) begin
                            next_s.rdata = id_word;                           // R2
                        end else if (is_cfg) begin
                            next_s.rdata = s.cfg;
                        end else begin
                            next_s.rdata = WORD_ZERO;
                        end
                    end
                    OP_WRITE: begin
                        if (is_pm) begin
                            pmem_we = 1'b1;
                        end else if (is_id) begin
                            next_s.ids[id_idx] = link_wdata;                  // R2
                        end else if (is_cfg) begin
                            next_s.cfg    = cfg_wr;                           // R13
                            next_s.reject = (cfg_wr != link_wdata);           // R13
                        end
                    end
                    OP_BULK: begin
                        next_s.reject = 1'b1;                                 // R6
                    end
                    OP_RSVD: begin
                        next_s.reject = 1'b1;
                    end
                endcase
            end
        end

        // shared pin: gpio only when low-voltage entry is off
        next_s.pin_o   = low_voltage_program_enable ? 1'b0 : gpio_out_i;                             // R12
        next_s.pin_oe  = low_voltage_program_enable ? 1'b0 : gpio_oe_i;                              // R8
        next_s.gpio_in = low_voltage_program_enable ? 1'b0 : s.pgm_s;                                // R12
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s         <= '0;
            s.mode    <= PME_IDLE;
            s.cfg     <= CFG_ERASED;                                          // R7
            s.ids     <= {ID_COUNT{ID_ERASED}};
            s.rdata   <= WORD_ZERO;
        end else begin
            s <= next_s;
        end
    end

    // array kept out of the reset domain: a real part holds it in flash
    always_ff @(posedge clock_i) begin
        if (pmem_we) begin
            pmem[pm_idx] <= link_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign program_mode_o               = (s.mode != PME_IDLE);
    assign hv_session_o                 = (s.mode == PME_HV);
    assign low_voltage_program_enable_o = low_voltage_program_enable;
    assign cmd_reject_o                 = s.reject;
    assign program_entry_pin_o          = s.pin_o;
    assign program_entry_pin_oe_o       = s.pin_oe;
    assign gpio_in_o                    = s.gpio_in;
    // link clock may stop mid-frame; the session level ends the drive here
    assign link_data_oe_o               = link_oe && program_mode_o;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_live_req;
        req_new && s.mode != PME_IDLE;
    endsequence

    sequence s_read_pm;
        s_live_req ##0 (op == OP_READ && is_pm);
    endsequence

    a_verify_read: assert property (s_read_pm ##0 !prot |=>                // R1
        s.rdata == pmem[$past(pm_idx)])
        else $error("unprotected read did not return program word");

    a_protect_read: assert property (s_read_pm ##0 prot |=>                // R1
        s.rdata == WORD_ZERO)
        else $error("protected read leaked program word");

    a_id_read: assert property (s_live_req ##0 (op == OP_READ && is_id) |=> // R2
        s.rdata == $past(id_word))
        else $error("id read returned wrong word");

    a_id_gate: assert property (s.mode == PME_IDLE |=> $stable(s.ids))      // R3
        else $error("id word changed outside a session");

    a_bulk_refuse: assert property (s_live_req ##0 op == OP_BULK |->       // R6
        !pmem_we ##1 cmd_reject_o)
        else $error("bulk operation not refused");

    a_lv_locked: assert property (s.mode == PME_IDLE && !low_voltage_program_enable && !s.hv_s |=> // R7
        s.mode != PME_LV)
        else $error("low-voltage entry with enable bit cleared");

    a_entry_pin: assert property (low_voltage_program_enable |=> !program_entry_pin_oe_o &&       // R8
        !gpio_in_o)
        else $error("entry pin used as gpio while low-voltage enabled");

    a_lv_entry: assert property (s.mode == PME_IDLE && low_voltage_program_enable && s.pgm_s &&   // R9
        !s.hv_s |=> s.mode == PME_LV)
        else $error("entry pin high did not start low-voltage session");

    a_hv_entry: assert property (s.mode == PME_IDLE && s.hv_s |=>          // R11
        s.mode == PME_HV)
        else $error("high voltage did not start a session");

    a_gpio_pass: assert property (!low_voltage_program_enable |=> program_entry_pin_oe_o ==       // R12
        $past(gpio_oe_i) && program_entry_pin_o == $past(gpio_out_i))
        else $error("shared pin not following gpio drive");

    a_cfg_lock: assert property (s.mode == PME_LV |=> $stable(low_voltage_program_enable))        // R13
        else $error("enable bit changed in low-voltage session");

    a_path_hold: assert property ((s.mode == PME_HV && s.hv_s) or          // R14
        (s.mode == PME_LV && s.pgm_s) |=> $stable(s.mode))
        else $error("entry path changed inside a session");

    sequence s_live_write;
        s_live_req ##0 op == OP_WRITE;
    endsequence

    a_id_write: assert property (s_live_write ##0 is_id |=>                // R2
        s.ids[$past(id_idx)] == $past(link_wdata))
        else $error("id write did not land");

    a_hv_cfg_write: assert property (s_live_write ##0 (is_cfg && s.mode == PME_HV) |=> // R13
        s.cfg == $past(link_wdata) && !cmd_reject_o)
        else $error("config write refused in high-voltage session");

    a_lv_cfg_refuse: assert property (s_live_write ##0 (is_cfg && s.mode == PME_LV) |=> // R13
        cmd_reject_o == ($past(link_wdata[CFG_LVP_BIT]) != low_voltage_program_enable))
        else $error("enable bit write not flagged in low-voltage session");

    a_gpio_sense: assert property (!low_voltage_program_enable |=> gpio_in_o == $past(s.pgm_s))   // R12
        else $error("shared pin level not passed to core");

    a_hv_exit: assert property (s.mode == PME_HV && !s.hv_s |=>            // R14
        s.mode == PME_IDLE)
        else $error("high-voltage session outlived its entry signal");

    a_lv_exit: assert property (s.mode == PME_LV && !s.pgm_s |=>           // R14
        s.mode == PME_IDLE)
        else $error("low-voltage session outlived its entry pin");

endmodule // pme_ctrl

// ### pme_prog_model.sv
/*
 * Serial programmer model: link clock, data line, framed requests.
 * Assumes the device samples data on the rising link edge and drives
 * read answers that are sampled on the falling edge.
 */
`timescale 1ns/1ps
module pme_prog_model (
    input  wire logic line_i,      // resolved data line
    output logic      link_clk_o,  // link clock, still between frames except for bare pulses
    output logic      link_data_o  // programmer data drive
);
    initial begin
        link_clk_o  = 1'b0;
        link_data_o = 1'b0;
    end
    // bare pulses let the session level cross into the link domain
    task automatic pulse(input int n);
        repeat (n) begin
            #16 link_clk_o = 1'b1;
            #16 link_clk_o = 1'b0;
        end
    endtask
    task automatic frame(input logic [1:0] op, input logic [13:0] a, d,
                         output logic [13:0] rd);
        logic [29:0] f;
        f  = {d, a, op};
        rd = 14'h0000;
        for (int i = 0; i < 30; i++) begin
            // released line toggles so no stale level can pass for data
            link_data_o = (op == 2'h0 && i > 15) ? ~link_data_o : f[i];
            pulse(1);
            if (i > 14 && i < 29) begin
                rd[i-15] = line_i;
            end
        end
    endtask
endmodule // pme_prog_model

// ### tb_top.sv
/*
 * Bench for the program-mode entry controller.
 * Assumes the programmer model owns the link; pins change at falling edges.
 */
`timescale 1ns/1ps
module tb_top;
    import pme_pkg::*;
    logic        clock_i, arst_n_i, hv, pin_drv, gpio_out, gpio_oe, gpio_in;
    logic        pin_o, pin_oe, ld_o, ld_oe, mode, hv_s, low_voltage_program_enable, rej;
    logic        lclk, m_data, line, pin;
    logic [13:0] rd;
    int          bad_count, n_compared, rej_cnt;
    assign line = ld_oe ? ld_o : m_data;
    assign pin  = pin_oe ? pin_o : pin_drv;
    pme_ctrl pme_ctrl_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .link_clk_i(lclk),
        .master_clear_pin_hv_i(hv), .program_entry_pin_i(pin),
        .program_entry_pin_o(pin_o), .program_entry_pin_oe_o(pin_oe),
        .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in),
        .link_data_i(line), .link_data_o(ld_o), .link_data_oe_o(ld_oe),
        .program_mode_o(mode), .hv_session_o(hv_s),
        .low_voltage_program_enable_o(low_voltage_program_enable), .cmd_reject_o(rej));
    pme_prog_model pme_prog_model_i (.line_i(line), .link_clk_o(lclk), .link_data_o(m_data));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (rej === 1'b1) rej_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [13:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk(nm, {13'h0000, e}, {13'h0000, g});
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wait_mode(input logic v);
        int n;
        n = 0;
        while (mode !== v && n < 20) begin
            @(negedge clock_i);
            n++;
        end
        chk1("program_mode", v, mode);
        if (mode !== v) conclude();
        pme_prog_model_i.pulse(2);
    endtask
    // write effects land a few system cycles after the frame
    task automatic wr(input logic [1:0] op, input logic [13:0] a, d);
        pme_prog_model_i.frame(op, a, d, rd);
        #40;
    endtask
    // read answers come one frame late
    task automatic rdw(input logic [13:0] a);
        pme_prog_model_i.frame(OP_READ, a, 14'h0000, rd);
        #40;
        pme_prog_model_i.frame(OP_READ, a, 14'h0000, rd);
    endtask
    task automatic leave();
        @(negedge clock_i);
        hv = 1'b0;
        pin_drv = 1'b0;
        wait_mode(1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_lv();
        @(negedge clock_i);
        gpio_oe = 1'b1;
        gpio_out = 1'b1;
        hv = 1'b0;
        pin_drv = 1'b1;
        wait_mode(1'b1);
        chk1("hv_session", 1'b0, hv_s);
        chk1("pin_oe", 1'b0, pin_oe);
        chk1("gpio_in", 1'b0, gpio_in);
        wr(OP_WRITE, CFG_ADDR, 14'h3F7F);
        chk1("lvp", 1'b1, low_voltage_program_enable);
        chk("rejects", 14'h0001, 14'(rej_cnt));
        wr(OP_WRITE, 14'h0010, 14'h1234);
        wr(OP_BULK, 14'h0010, 14'h0000);
        wr(OP_RSVD, 14'h0010, 14'h0000);
        chk("rejects", 14'h0003, 14'(rej_cnt));
        rdw(14'h0010);
        chk("pmem", 14'h1234, rd);
        wr(OP_WRITE, ID_LAST, 14'h0005);
        rdw(ID_LAST);
        chk("id3", 14'h0005, rd);
        leave();
        $display("test lv entry done");
    endtask
    task automatic t_hv();
        @(negedge clock_i);
        hv = 1'b1;
        wait_mode(1'b1);
        chk1("hv_session", 1'b1, hv_s);
        wr(OP_WRITE, CFG_ADDR, 14'h3F4F);
        chk1("lvp", 1'b0, low_voltage_program_enable);
        chk("rejects", 14'h0003, 14'(rej_cnt));
        rdw(14'h0010);
        chk("pmem", 14'h0000, rd);
        wr(OP_WRITE, ID_BASE, 14'h000A);
        rdw(ID_BASE);
        chk("id0", 14'h000A, rd);
        leave();
        @(negedge clock_i);
        gpio_oe = 1'b0;
        pin_drv = 1'b1;
        repeat (10) @(negedge clock_i);
        chk1("program_mode", 1'b0, mode);
        chk1("gpio_in", 1'b1, gpio_in);
        gpio_oe = 1'b1;
        gpio_out = 1'b0;
        repeat (6) @(negedge clock_i);
        chk1("pin_oe", 1'b1, pin_oe);
        chk1("gpio_in", 1'b0, gpio_in);
        hv = 1'b1;
        wait_mode(1'b1);
        leave();
        $display("test hv entry done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {hv, pin_drv, gpio_out, gpio_oe} = 4'h0;
        {bad_count, n_compared, rej_cnt} = {32'd0, 32'd0, 32'd0};
        arst_n_i = 1'b0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        chk1("lvp", 1'b1, low_voltage_program_enable);
        chk1("pin_oe", 1'b0, pin_oe);
        $display("test reset done");
        t_lv();
        t_hv();
        conclude();
    end
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
endmodule // tb_top
